/* File: src/tpc_pkg.sv */
// package and input synchroniser for the training pattern command block
`default_nettype none

package tpc_pkg;
  // ----------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OPC_PROG_NV = 8'h43;  // program nonvolatile copy
  localparam logic [7:0] OPC_WR_VOL  = 8'h4a;  // write volatile copy
  localparam logic [7:0] OPC_RD_PAT  = 8'h41;  // read volatile copy

  // ----------------------------------------------------------------
  // widths, reset values, timing
  // ----------------------------------------------------------------
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;   // bits in a data byte
  localparam logic [3:0] STEP_SINGLE   = 4'h1;   // bits per edge, single line
  localparam logic [3:0] STEP_QUAD     = 4'h4;   // bits per edge, quad mode
  localparam logic [7:0] PAT_RST       = 8'h00;  // pattern reset value
  localparam int         CLK_PERIOD_NS = 5;      // sys_clk_i period
  localparam int         BUSY_W        = 24;     // busy counter width
  localparam logic [3:0] OE_N_ALL_OFF  = 4'hf;   // all lines released
  localparam logic [3:0] OE_N_SO_ONLY  = 4'hd;   // only line 1 driven

  // ----------------------------------------------------------------
  // command sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,  // chip select high
    ST_OPC    = 3'b001,  // shifting opcode
    ST_DATA   = 3'b010,  // shifting data byte
    ST_DONE   = 3'b011,  // exactly one data byte held
    ST_RDOUT  = 3'b100,  // pattern shifting out
    ST_IGNORE = 3'b101   // command discarded until deselect
  } tpc_st_t;
endpackage : tpc_pkg

// ------------------------------------------------------------------
// two-flop synchroniser
// ------------------------------------------------------------------
module tpc_sync2 #(
  parameter int W = 6
) (
  // clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         rst_n_i,
  // async in, synced out
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_ff;  // first stage, read only by the second

  // plain two-stage capture
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_ff <= '0;
      sync_o  <= '0;
    end else begin
      meta_ff <= async_i;
      sync_o  <= meta_ff;
    end
  end
endmodule : tpc_sync2

`default_nettype wire

/* File: src/tpc_pattern_cmd.sv */
// training pattern register command handling, device side
// ------------------------------------------------------------------
// Functional notes
// - nonvolatile program needs write enable latch set
// - opcode 43h then one data byte
// - nonvolatile program discarded unless exact byte boundary
// - program self-timed, busy flag high while running
// - failed program raises program error flag
// - program completion clears write enable latch
// - volatile write needs write enable latch set
// - opcode 4Ah then one data byte
// - volatile write discarded unless exact byte boundary
// - volatile write applied at deselect, no busy
// - opcode 41h shifts out volatile pattern
// - pattern repeats every further eight clocks single line, every two in quad
// - two pattern copies, nonvolatile and volatile
// - enabled pattern driven on all lines in window
// - all commands work single line and quad
// ------------------------------------------------------------------
`default_nettype none

module tpc_pattern_cmd #(
  parameter int unsigned PROG_TIME_NS = 200000  // self-timed program time
) (
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  // serial pins from the host
  input  wire logic       cs_n_i,
  input  wire logic       sck_i,
  input  wire logic [3:0] io_i,
  output logic      [3:0] io_o,
  output logic      [3:0] io_oe_n_o,
  // device control and status
  input  wire logic       quad_command_mode_i,
  input  wire logic       write_enable_cmd_i,
  input  wire logic       prog_fail_i,
  input  wire logic       pattern_enable_bit_i,
  input  wire logic       pattern_window_i,
  output logic            write_enable_latch_o,
  output logic            write_in_progress_o,
  output logic            prog_err_o,
  output logic      [7:0] nonvolatile_pattern_reg_o,
  output logic      [7:0] volatile_pattern_reg_o
);
  // ----------------------------------------------------------------
  // derived timing
  // ----------------------------------------------------------------
  localparam int unsigned PROG_CYC_I =
    (PROG_TIME_NS + tpc_pkg::CLK_PERIOD_NS - 1) / tpc_pkg::CLK_PERIOD_NS;
  localparam logic [tpc_pkg::BUSY_W-1:0] PROG_CYC =
    PROG_CYC_I[tpc_pkg::BUSY_W-1:0];
  // one at counter width, so the countdown never mixes widths
  localparam logic [tpc_pkg::BUSY_W-1:0] BCNT_ONE =
    {{(tpc_pkg::BUSY_W-1){1'b0}}, 1'b1};

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    tpc_pkg::tpc_st_t          st;       // sequencer state
    logic                      cs_prev;  // last synced chip select
    logic                      sck_prev; // last synced serial clock
    logic [3:0]                cnt;      // bits of current byte
    logic [7:0]                sh;       // input shifter
    logic [7:0]                opc;      // accepted write opcode
    logic [7:0]                dat;      // captured data byte
    logic [7:0]                rot;      // read rotator
    logic [7:0]                dsh;      // window pattern rotator
    logic                      pat_on;   // window active last cycle
    logic [3:0]                dout;     // line output values
    logic [3:0]                oe_n;     // line enables, low drives
    logic                      wlat;     // write enable latch
    logic                      busy;     // write in progress
    logic                      perr;     // program error
    logic [tpc_pkg::BUSY_W-1:0] bcnt;    // busy countdown
    logic [7:0]                nv_pat;   // nonvolatile copy
    logic [7:0]                v_pat;    // volatile copy
  } tpc_state_t;

  tpc_state_t q_ff;   // registered state
  tpc_state_t nxt_q;  // next state

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  // chip select enters inverted: the cleared synchroniser then reads
  // as deselected, so no false select edge follows reset
  logic [5:0] pins_s;  // {cs active high, sck, io}
  tpc_sync2 #(.W(6)) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .async_i   ({~cs_n_i, sck_i, io_i}),
    .sync_o    (pins_s)
  );

  logic       cs_n_s;    // synced chip select
  logic       sck_s;     // synced serial clock
  logic [3:0] io_s;      // synced data lines
  logic       cs_rise;   // deselect edge
  logic       cs_fall;   // select edge
  logic       sck_rise;  // sample edge
  logic       sck_fall;  // launch edge
  logic       pat_act;   // pattern window in force
  logic [3:0] step;      // bits per clock edge
  assign cs_n_s   = ~pins_s[5];
  assign sck_s    = pins_s[4];
  assign io_s     = pins_s[3:0];
  assign cs_rise  = cs_n_s & ~q_ff.cs_prev;
  assign cs_fall  = ~cs_n_s & q_ff.cs_prev;
  assign sck_rise = sck_s & ~q_ff.sck_prev;
  assign sck_fall = ~sck_s & q_ff.sck_prev;
  assign pat_act  = pattern_enable_bit_i & pattern_window_i;
  assign step     = quad_command_mode_i ? tpc_pkg::STEP_QUAD
                                        : tpc_pkg::STEP_SINGLE;

  // msb-first shift, one or four bits per rising edge
  function automatic logic [7:0] shift_in(input logic [7:0] s,
                                          input logic       quad,
                                          input logic [3:0] d);
    shift_in = quad ? {s[3:0], d} : {s[6:0], d[0]};
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] sh;
    logic [3:0] cnt;
    sh       = shift_in(q_ff.sh, quad_command_mode_i, io_s);
    cnt      = q_ff.cnt + step;
    nxt_q    = q_ff;
    nxt_q.cs_prev  = cs_n_s;
    nxt_q.sck_prev = sck_s;

    // self-timed program countdown
    if (q_ff.busy) begin
      if (q_ff.bcnt <= BCNT_ONE) begin
        nxt_q.busy = 1'b0;
        nxt_q.wlat = 1'b0;
        nxt_q.perr = prog_fail_i;
        if (!prog_fail_i) begin
          nxt_q.nv_pat = q_ff.dat;
        end
      end else begin
        nxt_q.bcnt = q_ff.bcnt - BCNT_ONE;
      end
    end

    if (cs_rise) begin
      // only a full single data byte executes
      if (q_ff.st == tpc_pkg::ST_DONE && q_ff.wlat && !q_ff.busy) begin
        if (q_ff.opc == tpc_pkg::OPC_PROG_NV) begin
          nxt_q.busy = 1'b1;
          nxt_q.bcnt = PROG_CYC;
          nxt_q.perr = 1'b0;
        end else begin
          nxt_q.v_pat = q_ff.dat;
        end
      end
      nxt_q.st = tpc_pkg::ST_IDLE;
    end else if (cs_fall) begin
      // new command frame
      nxt_q.st  = tpc_pkg::ST_OPC;
      nxt_q.cnt = 4'h0;
    end else if (!cs_n_s && sck_rise) begin
      // sample on rising edge
      case (q_ff.st)
        tpc_pkg::ST_OPC: begin
          nxt_q.sh  = sh;
          nxt_q.cnt = cnt;
          if (cnt == tpc_pkg::BITS_PER_BYTE) begin
            nxt_q.cnt = 4'h0;
            if (sh == tpc_pkg::OPC_RD_PAT) begin
              nxt_q.st  = tpc_pkg::ST_RDOUT;
              nxt_q.rot = q_ff.v_pat;
            end else if ((sh == tpc_pkg::OPC_PROG_NV ||
                          sh == tpc_pkg::OPC_WR_VOL) &&
                         q_ff.wlat && !q_ff.busy) begin
              nxt_q.st  = tpc_pkg::ST_DATA;
              nxt_q.opc = sh;
            end else begin
              nxt_q.st = tpc_pkg::ST_IGNORE;   // not ours or not enabled
            end
          end
        end
        tpc_pkg::ST_DATA: begin
          nxt_q.sh  = sh;
          nxt_q.cnt = cnt;
          if (cnt == tpc_pkg::BITS_PER_BYTE) begin
            nxt_q.dat = sh;
            nxt_q.st  = tpc_pkg::ST_DONE;
          end
        end
        tpc_pkg::ST_DONE: begin
          nxt_q.st = tpc_pkg::ST_IGNORE;
        end
        default: begin
          nxt_q.st = q_ff.st;                  // idle, reading, ignoring
        end
      endcase
    end else if (!cs_n_s && sck_fall && q_ff.st == tpc_pkg::ST_RDOUT) begin
      // launch on falling edge; rotation repeats the byte
      if (quad_command_mode_i) begin
        nxt_q.dout = q_ff.rot[7:4];
        nxt_q.rot  = {q_ff.rot[3:0], q_ff.rot[7:4]};
      end else begin
        nxt_q.dout = {2'b00, q_ff.rot[7], 1'b0};
        nxt_q.rot  = {q_ff.rot[6:0], q_ff.rot[7]};
      end
    end

    // pattern window for double-rate reads, one bit per edge
    nxt_q.pat_on = pat_act;
    if (pat_act) begin
      if (!q_ff.pat_on) begin
        nxt_q.dsh = q_ff.v_pat;
      end else if (sck_rise || sck_fall) begin
        nxt_q.dsh = {q_ff.dsh[6:0], q_ff.dsh[7]};
      end
      nxt_q.dout = {4{nxt_q.dsh[7]}};
    end

    // line enables follow the next state, so writes drive only inside the pattern window
    if (pat_act) begin
      nxt_q.oe_n = 4'h0;
    end else if (nxt_q.st == tpc_pkg::ST_RDOUT) begin
      nxt_q.oe_n = quad_command_mode_i ? 4'h0 : tpc_pkg::OE_N_SO_ONLY;
    end else begin
      nxt_q.oe_n = tpc_pkg::OE_N_ALL_OFF;
    end

    // a set arriving with the completion clear wins
    if (write_enable_cmd_i) begin
      nxt_q.wlat = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_ff        <= '0;
      q_ff.st     <= tpc_pkg::ST_IDLE;
      q_ff.cs_prev <= 1'b1;
      q_ff.oe_n   <= tpc_pkg::OE_N_ALL_OFF;
      q_ff.nv_pat <= tpc_pkg::PAT_RST;
      q_ff.v_pat  <= tpc_pkg::PAT_RST;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign io_o                      = q_ff.dout;
  assign io_oe_n_o                 = q_ff.oe_n;
  assign write_enable_latch_o      = q_ff.wlat;
  assign write_in_progress_o       = q_ff.busy;
  assign prog_err_o                = q_ff.perr;
  assign nonvolatile_pattern_reg_o = q_ff.nv_pat;
  assign volatile_pattern_reg_o    = q_ff.v_pat;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_prog_needs_latch: assert property (
    $rose(q_ff.busy) |-> $past(q_ff.wlat))
    else $error("program started without write enable");
  a_prog_starts: assert property (
    cs_rise && q_ff.st == tpc_pkg::ST_DONE && q_ff.wlat && !q_ff.busy &&
    q_ff.opc == tpc_pkg::OPC_PROG_NV |=> q_ff.busy)
    else $error("program did not start at deselect");
  a_partial_drop: assert property (
    cs_rise && q_ff.st != tpc_pkg::ST_DONE |=>
    !$rose(q_ff.busy) && $stable(q_ff.v_pat))
    else $error("partial command executed");
  a_latch_cleared: assert property (
    $fell(q_ff.busy) |-> !q_ff.wlat || $past(write_enable_cmd_i))
    else $error("write enable latch left set after program");
  a_err_report: assert property (
    $fell(q_ff.busy) |-> q_ff.perr == $past(prog_fail_i))
    else $error("program error flag wrong");
  a_vol_write: assert property (
    cs_rise && q_ff.st == tpc_pkg::ST_DONE && q_ff.wlat && !q_ff.busy &&
    q_ff.opc == tpc_pkg::OPC_WR_VOL |=>
    q_ff.v_pat == $past(q_ff.dat) && !q_ff.busy)
    else $error("volatile write not applied at once");
  a_vol_needs_latch: assert property (
    $changed(q_ff.v_pat) |-> $past(q_ff.wlat))
    else $error("volatile write without write enable");
  a_write_hiz: assert property (
    (q_ff.st == tpc_pkg::ST_DATA || q_ff.st == tpc_pkg::ST_DONE) &&
    !q_ff.pat_on |-> io_oe_n_o == tpc_pkg::OE_N_ALL_OFF)
    else $error("output driven during write command");
  a_read_load: assert property (
    $rose(q_ff.st == tpc_pkg::ST_RDOUT) |-> q_ff.rot == q_ff.v_pat)
    else $error("read did not load volatile pattern");

endmodule : tpc_pattern_cmd

`default_nettype wire

/* File: tb/tpc_host_model.sv */
// host controller model that drives the serial link of the pattern block
`default_nettype none

module tpc_host_model (
  // system clock, paces the link
  input  wire logic       sys_clk_i,
  // resolved data lines and device enables
  input  wire logic [3:0] io_i,
  input  wire logic [3:0] dev_oe_n_i,
  // link pins towards the device
  output logic            cs_n_o,
  output logic            sck_o,
  output logic      [3:0] io_o,
  // sticky flag: device drove a line while the host was shifting
  output logic            oe_bad_o
);
  timeunit 1ns;
  timeprecision 1ps;

  localparam int HALF = 16;  // half of the 160 ns link clock

  // idle link: deselected, clock parked low
  initial begin
    cs_n_o   = 1'b1;
    sck_o    = 1'b0;
    io_o     = 4'h0;
    oe_bad_o = 1'b0;
  end

  task automatic half_wait();
    repeat (HALF) @(posedge sys_clk_i);
  endtask

  // ----------------------------------------------------------------
  // one frame: opcode, nd data bits, then nrd bytes read back
  // ----------------------------------------------------------------
  task automatic xfer(input logic [7:0] opc, input logic [7:0] dat,
                      input int nd, input logic q, input int nrd,
                      output logic [7:0] rd);
    logic [23:0] sh;
    int          step;
    sh   = {opc, dat, 8'h00};
    step = q ? 4 : 1;
    rd   = 8'h00;
    @(posedge sys_clk_i) cs_n_o <= 1'b0;
    for (int i = 0; i < 8 + nd; i += step) begin
      io_o <= q ? sh[23-i -: 4] : {io_o[3:1], sh[23-i]};
      half_wait();
      sck_o <= 1'b1;
      // shifting phase: every line must stay released
      if (dev_oe_n_i !== 4'hf) oe_bad_o <= 1'b1;
      half_wait();
      sck_o <= 1'b0;
    end
    for (int i = 0; i < nrd * (q ? 2 : 8); i++) begin
      io_o <= ~io_o;  // host released: garbage that keeps changing
      half_wait();
      sck_o <= 1'b1;
      rd = q ? {rd[3:0], io_i} : {rd[6:0], io_i[1]};
      half_wait();
      sck_o <= 1'b0;
    end
    half_wait();
    cs_n_o <= 1'b1;
    io_o   <= ~io_o;
    // deselect gap, well above the minimum of 4 clocks
    repeat (8) @(posedge sys_clk_i);
  endtask
endmodule // tpc_host_model

`default_nettype wire

/* File: tb/tpc_pattern_cmd_tb.sv */
// self-checking bench for the training pattern command block
`default_nettype none

module tpc_pattern_cmd_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic       sys_clk, rst_n, cs_n, sck, quad, wen, fail, pen, pwin;
  logic [3:0] host_io, dev_io, dev_oe_n, io_bus;
  logic       wlat, busy, perr, oe_bad;
  logic [7:0] nv, vol, d, d2, rd;
  int         mismatches, samples_checked, seed;

  // a line carries the device value only where the device drives it
  assign io_bus = (dev_io & ~dev_oe_n) | (host_io & dev_oe_n);

  always #2.5 sys_clk = ~sys_clk;  // 200 MHz

  // short program time keeps the run brief
  tpc_pattern_cmd #(.PROG_TIME_NS(100)) i_tpc_pattern_cmd (
    .sys_clk_i(sys_clk), .rst_n_i(rst_n), .cs_n_i(cs_n), .sck_i(sck),
    .io_i(io_bus), .io_o(dev_io), .io_oe_n_o(dev_oe_n),
    .quad_command_mode_i(quad), .write_enable_cmd_i(wen),
    .prog_fail_i(fail), .pattern_enable_bit_i(pen),
    .pattern_window_i(pwin), .write_enable_latch_o(wlat),
    .write_in_progress_o(busy), .prog_err_o(perr),
    .nonvolatile_pattern_reg_o(nv), .volatile_pattern_reg_o(vol));

  tpc_host_model i_tpc_host_model (
    .sys_clk_i(sys_clk), .io_i(io_bus), .dev_oe_n_i(dev_oe_n),
    .cs_n_o(cs_n), .sck_o(sck), .io_o(host_io), .oe_bad_o(oe_bad));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // a write lands only on a whole byte with the latch set
  function automatic logic [7:0] exp_wr(logic [7:0] old, logic [7:0] nw,
                                        int nd, logic latch);
    return (nd == 8 && latch) ? nw : old;
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      mismatches++;
    end
  endtask

  task automatic close_out();
    $display("mismatches=%0d samples_checked=%0d", mismatches,
             samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // one-cycle write enable pulse
  task automatic wen_pulse();
    @(posedge sys_clk) wen <= 1'b1;
    @(posedge sys_clk) wen <= 1'b0;
  endtask

  // bounded wait for the busy flag to drop
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy === 1'b1 && n < 400) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 400) begin
      mismatches++;
      close_out();
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0; rst_n = 1'b0; quad = 1'b0; wen = 1'b0;
    fail = 1'b0; pen = 1'b0; pwin = 1'b0;
    mismatches = 0; samples_checked = 0;
    seed = $urandom(13);
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk(vol, tpc_pkg::PAT_RST);
    chk(nv, tpc_pkg::PAT_RST);
    chk(8'({wlat, busy, perr}), 8'h00);
    chk(8'(dev_oe_n), 8'(tpc_pkg::OE_N_ALL_OFF));
    // writes with the latch clear are ignored
    i_tpc_host_model.xfer(tpc_pkg::OPC_WR_VOL, 8'h5a, 8, 0, 0, rd);
    chk(vol, exp_wr(8'h00, 8'h5a, 8, 1'b0));
    i_tpc_host_model.xfer(tpc_pkg::OPC_PROG_NV, 8'h5a, 8, 0, 0, rd);
    chk(nv, exp_wr(8'h00, 8'h5a, 8, 1'b0));
    chk(8'(busy), 8'h00);
    // short and long data bytes are discarded
    wen_pulse();
    for (int nd = 7; nd <= 9; nd += 2) begin
      i_tpc_host_model.xfer(tpc_pkg::OPC_WR_VOL, 8'ha5, nd, 0, 0,
                            rd);
      chk(vol, exp_wr(8'h00, 8'ha5, nd, 1'b1));
      i_tpc_host_model.xfer(tpc_pkg::OPC_PROG_NV, 8'ha5, nd, 0, 0,
                            rd);
      chk(nv, exp_wr(8'h00, 8'ha5, nd, 1'b1));
    end
    chk(8'(wlat), 8'h01);
    // single line, then quad: write, read back, program
    for (int q = 0; q < 2; q++) begin
      quad <= q[0];
      d  = 8'($urandom());
      d2 = 8'($urandom());
      wen_pulse();
      i_tpc_host_model.xfer(tpc_pkg::OPC_WR_VOL, d, 8, q[0], 0, rd);
      chk(vol, exp_wr(8'h00, d, 8, 1'b1));
      chk(8'(busy), 8'h00);
      i_tpc_host_model.xfer(tpc_pkg::OPC_RD_PAT, 8'h00, 0, q[0], 3,
                            rd);
      chk(rd, d);
      wen_pulse();
      i_tpc_host_model.xfer(tpc_pkg::OPC_PROG_NV, d2, 8, q[0], 0,
                            rd);
      chk(8'(busy), 8'h01);
      wait_idle();
      chk(8'(busy), 8'h00);
      chk(8'(wlat), 8'h00);
      chk(nv, d2);
      chk(vol, d);
      chk(8'(perr), 8'h00);
    end
    // failing program raises the error flag and keeps the old copy
    quad <= 1'b0;
    fail <= 1'b1;
    wen_pulse();
    i_tpc_host_model.xfer(tpc_pkg::OPC_PROG_NV, ~d2, 8, 0, 0, rd);
    wait_idle();
    chk(8'(perr), 8'h01);
    chk(nv, d2);
    chk(8'(wlat), 8'h00);
    fail <= 1'b0;
    // training window drives every line with the pattern msb first
    pen  <= 1'b1;
    pwin <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk(8'(dev_oe_n), 8'h00);
    chk(8'(dev_io), 8'({4{d[7]}}));
    pen <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk(8'(dev_oe_n), 8'(tpc_pkg::OE_N_ALL_OFF));
    chk(8'(oe_bad), 8'h00);
    close_out();
  end
endmodule // tpc_pattern_cmd_tb

`default_nettype wire
